// ### pkg/psc_defines.svh
// Offsets, field positions, reset values and counts of the pulser and scaler block
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_OFF_PERIOD 16'h0080
`define PSC_OFF_LOW_TICKS 16'h0084
`define PSC_OFF_PULSE_COUNT 16'h0088
`define PSC_OFF_LAUNCH 16'h008C
`define PSC_OFF_FINISHED 16'h0090
`define PSC_OFF_FREEZE 16'h0100
`define PSC_OFF_SCALER_BASE 16'h0104

`define PSC_REG_RESET 32'h00000000
`define PSC_COUNT_OFF 32'h00000000
`define PSC_COUNT_ENDLESS 32'h0FFFFFFF
`define PSC_SCALER_FULL 32'hFFFFFFFF
`define PSC_FINISHED_BIT 0
`define PSC_FREEZE_BIT 0

`define PSC_NUM_SCALERS 35
`define PSC_IDX_W 6
`define PSC_NUM_PINS 32

`define PSC_IDX_REF 0
`define PSC_IDX_GLOBAL 1
`define PSC_IDX_PIN_LO 2
`define PSC_IDX_PIN_HI 16
`define PSC_IDX_BUSY_EDGE 17
`define PSC_IDX_BUSY_LEVEL 18
`define PSC_IDX_REAR_LO 19
`define PSC_IDX_REAR_HI 34
`define PSC_PIN_BUSY 15

`endif

// ### pkg/psc_pkg.sv
// Types shared by the pulser and scaler block
package psc_pkg;
   typedef logic [31:0] psc_word_t;
   typedef enum logic {PSC_PULSE_IDLE, PSC_PULSE_RUN} psc_pulse_state_t;
endpackage

// ### rtl/psc_scaler_bank.sv
// Bank of saturating scalers with a registered read port
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_scaler_bank
   import psc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic clearAll,
   input wire logic countEn,
   input wire logic [`PSC_NUM_SCALERS-1:0] incVec,
   input wire logic [`PSC_IDX_W-1:0] rdIdx,
   output psc_word_t rdData
);

   psc_word_t cnt_r [`PSC_NUM_SCALERS];
   psc_word_t rdData_r;

   // Add one unless already full
   function automatic psc_word_t satInc(input psc_word_t v);
      if (v == `PSC_SCALER_FULL) begin
         return v;
      end
      return v + 32'h00000001;
   endfunction

   // Counters, cleared together, held while frozen
   always_ff @(posedge clk) begin
      for (int i = 0; i < `PSC_NUM_SCALERS; i++) begin
         if (reset || clearAll) begin
            cnt_r[i] <= `PSC_REG_RESET;
         end else if (countEn && incVec[i]) begin
            cnt_r[i] <= satInc(cnt_r[i]);
         end
      end
   end

   // Registered read, out-of-range index reads zero
   always_ff @(posedge clk) begin
      if (reset) begin
         rdData_r <= `PSC_REG_RESET;
      end else if (rdIdx < `PSC_IDX_W'(`PSC_NUM_SCALERS)) begin
         rdData_r <= cnt_r[rdIdx];
      end else begin
         rdData_r <= `PSC_REG_RESET;
      end
   end

   assign rdData = rdData_r;

endmodule

// ### rtl/psc_pulser_scalers.sv
// Test pulser and signal scaler register block
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_pulser_scalers
   import psc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] regAddr,
   input wire logic regWr,
   input wire logic [31:0] regWrData,
   input wire logic regRd,
   output logic [31:0] regRdData,
   output logic regRdValid,
   input wire logic syncIn,
   input wire logic trig1In,
   input wire logic trig2In,
   input wire logic [1:0] nimOut,
   input wire logic [4:0] frontDiffIn,
   input wire logic [4:0] frontDiffOut,
   input wire logic busyIn,
   input wire logic [7:0] rearDiffIn,
   input wire logic [7:0] rearDiffOut,
   input wire logic globalTick,
   output logic pulserOut,
   output logic pulserFinished
);

   // Software settings
   psc_word_t period_r;
   psc_word_t lowTicks_r;
   psc_word_t pulseCount_r;
   logic freeze_r;

   // Pulser state
   psc_pulse_state_t pulseState_r;
   psc_pulse_state_t pulseState_nxt;
   psc_word_t phase_r;
   psc_word_t phase_nxt;
   psc_word_t delivered_r;
   psc_word_t delivered_nxt;
   logic pulserOut_r;
   logic pulserOut_nxt;
   logic finished_r;

   // Read path
   logic rdPending_r;
   logic rdFromBank_r;
   psc_word_t rdLocal_r;
   psc_word_t regRdData_r;
   logic regRdValid_r;

   // Pin synchronisers and edge detect
   logic [`PSC_NUM_PINS-1:0] pinRaw;
   logic [`PSC_NUM_PINS-1:0] pinMeta_r;
   logic [`PSC_NUM_PINS-1:0] pinSync_r;
   logic [`PSC_NUM_PINS-1:0] pinPrev_r;
   logic [`PSC_NUM_PINS-1:0] pinRise;

   // Address decode wires
   logic hitPeriod;
   logic hitLowTicks;
   logic hitPulseCount;
   logic hitLaunch;
   logic hitFinished;
   logic hitFreeze;
   logic hitScaler;
   logic [15:0] scalerOffset;
   logic [`PSC_IDX_W-1:0] scalerIdx;
   logic wrLaunch;
   logic wrFreeze;
   logic clearScalers;
   logic endless;
   logic countOff;
   logic periodEnd;
   psc_word_t periodEff;
   psc_word_t localRead;
   psc_word_t bankRdData;
   logic [`PSC_NUM_SCALERS-1:0] incVec;

   // Register address decode
   assign hitPeriod = (regAddr == `PSC_OFF_PERIOD);
   assign hitLowTicks = (regAddr == `PSC_OFF_LOW_TICKS);
   assign hitPulseCount = (regAddr == `PSC_OFF_PULSE_COUNT);
   assign hitLaunch = (regAddr == `PSC_OFF_LAUNCH);
   assign hitFinished = (regAddr == `PSC_OFF_FINISHED);
   assign hitFreeze = (regAddr == `PSC_OFF_FREEZE);
   assign scalerOffset = regAddr - `PSC_OFF_SCALER_BASE;
   assign scalerIdx = scalerOffset[`PSC_IDX_W+1:2];
   assign hitScaler = (regAddr >= `PSC_OFF_SCALER_BASE)
      && (scalerOffset[1:0] == 2'h0)
      && (scalerOffset[15:2] < 14'(`PSC_NUM_SCALERS));

   // Write strobes
   assign wrLaunch = regWr && hitLaunch;
   assign wrFreeze = regWr && hitFreeze;
   assign clearScalers = wrFreeze && !regWrData[`PSC_FREEZE_BIT];

   // Pulse-count modes
   assign countOff = (pulseCount_r == `PSC_COUNT_OFF);
   assign endless = (pulseCount_r == `PSC_COUNT_ENDLESS);

   // A zero period is taken as one tick so the phase always wraps
   assign periodEff = (period_r == `PSC_REG_RESET) ? 32'h00000001 : period_r;
   assign periodEnd = (phase_r == periodEff - 32'h00000001);

   // Settings registers
   always_ff @(posedge clk) begin
      if (reset) begin
         period_r <= `PSC_REG_RESET;
         lowTicks_r <= `PSC_REG_RESET;
         pulseCount_r <= `PSC_REG_RESET;
      end else if (regWr) begin
         if (hitPeriod) begin
            period_r <= regWrData;
         end
         if (hitLowTicks) begin
            lowTicks_r <= regWrData;
         end
         if (hitPulseCount) begin
            pulseCount_r <= regWrData;
         end
      end
   end

   // Freeze control
   always_ff @(posedge clk) begin
      if (reset) begin
         freeze_r <= 1'b0;
      end else if (wrFreeze) begin
         freeze_r <= regWrData[`PSC_FREEZE_BIT];
      end
   end

   // Pulser next-state logic
   always_comb begin
      pulseState_nxt = pulseState_r;
      phase_nxt = phase_r;
      delivered_nxt = delivered_r;
      pulserOut_nxt = 1'b0;
      case (pulseState_r)
         PSC_PULSE_IDLE: begin
            if (!countOff && (wrLaunch || endless)) begin
               pulseState_nxt = PSC_PULSE_RUN;
               phase_nxt = `PSC_REG_RESET;
               delivered_nxt = `PSC_REG_RESET;
               pulserOut_nxt = (lowTicks_r == `PSC_REG_RESET);
            end
         end
         PSC_PULSE_RUN: begin
            if (countOff) begin
               pulseState_nxt = PSC_PULSE_IDLE;
            end else if (wrLaunch) begin
               phase_nxt = `PSC_REG_RESET;
               delivered_nxt = `PSC_REG_RESET;
               pulserOut_nxt = (lowTicks_r == `PSC_REG_RESET);
            end else if (periodEnd) begin
               phase_nxt = `PSC_REG_RESET;
               delivered_nxt = delivered_r + 32'h00000001;
               pulserOut_nxt = (lowTicks_r == `PSC_REG_RESET);
               if (!endless && (delivered_nxt >= pulseCount_r)) begin
                  pulseState_nxt = PSC_PULSE_IDLE;
                  pulserOut_nxt = 1'b0;
               end
            end else begin
               phase_nxt = phase_r + 32'h00000001;
               pulserOut_nxt = (phase_nxt >= lowTicks_r);
            end
         end
         default: begin
            pulseState_nxt = PSC_PULSE_IDLE;
         end
      endcase
   end

   // Pulser registers
   always_ff @(posedge clk) begin
      if (reset) begin
         pulseState_r <= PSC_PULSE_IDLE;
         phase_r <= `PSC_REG_RESET;
         delivered_r <= `PSC_REG_RESET;
         pulserOut_r <= 1'b0;
      end else begin
         pulseState_r <= pulseState_nxt;
         phase_r <= phase_nxt;
         delivered_r <= delivered_nxt;
         pulserOut_r <= pulserOut_nxt;
      end
   end

   // Finished flag follows the pulser state
   always_ff @(posedge clk) begin
      if (reset) begin
         finished_r <= 1'b1;
      end else begin
         finished_r <= (pulseState_nxt == PSC_PULSE_IDLE);
      end
   end

   // Pin gathering, low index first
   assign pinRaw = {rearDiffOut, rearDiffIn, busyIn, frontDiffOut, frontDiffIn,
      nimOut, trig2In, trig1In, syncIn};

   // Two-stage synchroniser, then a history stage for edges
   always_ff @(posedge clk) begin
      if (reset) begin
         pinMeta_r <= '0;
         pinSync_r <= '0;
         pinPrev_r <= '0;
      end else begin
         pinMeta_r <= pinRaw;
         pinSync_r <= pinMeta_r;
         pinPrev_r <= pinSync_r;
      end
   end

   assign pinRise = pinSync_r & ~pinPrev_r;

   // Increment map for the scaler bank
   assign incVec[`PSC_IDX_REF] = 1'b1;
   assign incVec[`PSC_IDX_GLOBAL] = globalTick;
   assign incVec[`PSC_IDX_PIN_HI:`PSC_IDX_PIN_LO] = pinRise[14:0];
   assign incVec[`PSC_IDX_BUSY_EDGE] = pinRise[`PSC_PIN_BUSY];
   assign incVec[`PSC_IDX_BUSY_LEVEL] = pinSync_r[`PSC_PIN_BUSY];
   assign incVec[`PSC_IDX_REAR_HI:`PSC_IDX_REAR_LO] = pinRise[31:16];

   // Scaler storage
   psc_scaler_bank uBank (
      .clk(clk),
      .reset(reset),
      .clearAll(clearScalers),
      .countEn(!freeze_r),
      .incVec(incVec),
      .rdIdx(scalerIdx),
      .rdData(bankRdData)
   );

   // Local register read mux; launch and unmapped read zero
   assign localRead =
      hitPeriod ? period_r :
      hitLowTicks ? lowTicks_r :
      hitPulseCount ? pulseCount_r :
      hitFinished ? {31'h00000000, finished_r} :
      hitFreeze ? {31'h00000000, freeze_r} :
      `PSC_REG_RESET;

   // First read stage
   always_ff @(posedge clk) begin
      if (reset) begin
         rdPending_r <= 1'b0;
         rdFromBank_r <= 1'b0;
         rdLocal_r <= `PSC_REG_RESET;
      end else begin
         rdPending_r <= regRd;
         rdFromBank_r <= hitScaler;
         rdLocal_r <= localRead;
      end
   end

   // Second read stage drives the port
   always_ff @(posedge clk) begin
      if (reset) begin
         regRdData_r <= `PSC_REG_RESET;
         regRdValid_r <= 1'b0;
      end else begin
         regRdValid_r <= rdPending_r;
         if (rdPending_r) begin
            regRdData_r <= rdFromBank_r ? bankRdData : rdLocal_r;
         end
      end
   end

   // Outputs straight from flip-flops
   assign regRdData = regRdData_r;
   assign regRdValid = regRdValid_r;
   assign pulserOut = pulserOut_r;
   assign pulserFinished = finished_r;

endmodule

// ### tb/psc_pulser_scalers_assertions.sv
// Bus and pulser checks for the pulser and scaler block
`timescale 1ns/1ps
module psc_pulser_scalers_assertions
   import psc_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] regAddr,
   input wire logic regWr,
   input wire logic [31:0] regWrData,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   input wire logic regRdValid,
   input wire logic pulserOut,
   input wire logic pulserFinished
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [31:0] shadowCount_r;
   wire launchWr = regWr && regAddr == 16'h008C;
   wire countWr = regWr && regAddr == 16'h0088;
   // Shadow of the pulse-count setting
   always_ff @(posedge clk) begin
      if (reset) shadowCount_r <= 32'h0;
      else if (countWr) shadowCount_r <= regWrData;
   end
   sequence s_lone; regRd ##1 !regRd; endsequence
   property p_rdPulse; s_lone |-> ##1 regRdValid ##1 !regRdValid; endproperty
   a_rdPulse: assert property (p_rdPulse) else $error("read answer late or long");
   property p_rdCause; regRdValid |-> $past(regRd, 2); endproperty
   a_rdCause: assert property (p_rdCause) else $error("read answer without read");
   property p_launchRd; regRd && regAddr == 16'h008C |-> ##2 regRdData == 32'h0; endproperty
   a_launchRd: assert property (p_launchRd) else $error("launch reads nonzero");
   property p_finRd; regRd && regAddr == 16'h0090 |-> ##2 regRdData[31:1] == 31'h0; endproperty
   a_finRd: assert property (p_finRd) else $error("finished upper bits set");
   property p_zeroStop;
      countWr && regWrData == 32'h0 |=> ##1 (!pulserOut && pulserFinished)[*3];
   endproperty
   a_zeroStop: assert property (p_zeroStop) else $error("pulser runs at count zero");
   property p_launchGo; launchWr && shadowCount_r != 32'h0 |=> !pulserFinished; endproperty
   a_launchGo: assert property (p_launchGo) else $error("launch did not start");
   property p_launchIdle; launchWr && shadowCount_r == 32'h0 |=> pulserFinished; endproperty
   a_launchIdle: assert property (p_launchIdle) else $error("launch at zero ran");
   property p_holdIdle;
      pulserFinished && !launchWr && !countWr && shadowCount_r != 32'h0FFFFFFF |=> pulserFinished;
   endproperty
   a_holdIdle: assert property (p_holdIdle) else $error("pulser began unlaunched");
   property p_endless;
      shadowCount_r == 32'h0FFFFFFF && $past(shadowCount_r) == 32'h0FFFFFFF |-> !pulserFinished;
   endproperty
   a_endless: assert property (p_endless) else $error("endless train ended");
   property p_idleLow; pulserFinished |-> !pulserOut; endproperty
   a_idleLow: assert property (p_idleLow) else $error("output high while idle");
endmodule
bind psc_pulser_scalers psc_pulser_scalers_assertions chkInst (.clk(clk), .reset(reset),
   .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .regRd(regRd),
   .regRdData(regRdData), .regRdValid(regRdValid), .pulserOut(pulserOut),
   .pulserFinished(pulserFinished));

// ### tb/psc_pulser_scalers_bench.sv
// Self-checking bench for the pulser and scaler block
`timescale 1ns/1ps
module psc_pulser_scalers_bench
   import psc_pkg::*;
;
   logic clk = 0;
   logic reset = 1;
   logic regWr = 0;
   logic regRd = 0;
   logic [15:0] regAddr = 16'h0;
   logic [31:0] regWrData = 32'h0;
   logic [31:0] rdv;
   logic [31:0] refCnt;
   logic [34:0] pv = 35'h0;
   wire logic [31:0] regRdData;
   wire logic regRdValid, pulserOut, pulserFinished;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int k, i;
   int clrCyc;
   psc_pulser_scalers uut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWr(regWr),
      .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid),
      .syncIn(pv[2]), .trig1In(pv[3]), .trig2In(pv[4]), .nimOut(pv[6:5]),
      .frontDiffIn(pv[11:7]), .frontDiffOut(pv[16:12]), .busyIn(pv[17]),
      .rearDiffIn(pv[26:19]), .rearDiffOut(pv[34:27]), .globalTick(pv[1]),
      .pulserOut(pulserOut), .pulserFinished(pulserFinished));
   // Clock
   initial begin
      forever #5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         errors++;
         wrap_up();
      end
   end
   task automatic chk(input psc_word_t got, input psc_word_t exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic waitCyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      waitCyc(1);
      regWr = 1;
      regAddr = a;
      regWrData = d;
      waitCyc(1);
      regWr = 0;
   endtask
   task automatic rdChk(input logic [15:0] a, input logic [31:0] e);
      waitCyc(1);
      regRd = 1;
      regAddr = a;
      waitCyc(1);
      regRd = 0;
      waitCyc(1);
      chk({31'h0, regRdValid}, 32'h1);
      rdv = regRdData;
      chk(rdv, e);
   endtask
   task automatic wrap_up;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      waitCyc(8);
      reset = 0;
      rdChk(16'h0088, 32'h0);
      rdChk(16'h0090, 32'h1);
      rdChk(16'h0100, 32'h0);
      rdChk(16'h008C, 32'h0);
      rdChk(16'h00FC, 32'h0);
      rdChk(16'h0190, 32'h0);
      $display("register test done");
      // Period 4, low 1, two periods
      wr(16'h0080, 32'h4);
      wr(16'h0084, 32'h1);
      wr(16'h0088, 32'h2);
      waitCyc(5);
      chk({31'h0, pulserFinished}, 32'h1);
      wr(16'h008C, 32'hA5);
      for (k = 0; k < 9; k++) begin
         chk({31'h0, pulserOut}, {31'h0, k < 8 && k % 4 >= 1});
         chk({31'h0, pulserFinished}, {31'h0, k >= 8});
         waitCyc(1);
      end
      rdChk(16'h0088, 32'h2);
      $display("pulser test done");
      wr(16'h0088, 32'h0FFFFFFF);
      waitCyc(40);
      chk({31'h0, pulserFinished}, 32'h0);
      rdChk(16'h0090, 32'h0);
      wr(16'h0088, 32'h0);
      waitCyc(2);
      chk({30'h0, pulserFinished, pulserOut}, 32'h2);
      wr(16'h008C, 32'h1);
      waitCyc(6);
      chk({31'h0, pulserFinished}, 32'h1);
      $display("endless test done");
      // Pulse input i exactly i times, globalTick high two cycles
      wr(16'h0100, 32'h0);
      clrCyc = cyc;
      for (k = 0; k < 34; k++) begin
         for (i = 0; i < 35; i++) pv[i] = i != 18 && k < i;
         waitCyc(2);
         pv = 35'h0;
         waitCyc(2);
      end
      waitCyc(5);
      wr(16'h0100, 32'h1);
      refCnt = 32'(cyc - clrCyc);
      waitCyc(2);
      for (i = 1; i < 35; i++) begin
         rdChk(16'h0104 + 16'(4 * i), i == 1 ? 32'h2 : i == 18 ? 32'h22 : 32'(i));
      end
      rdChk(16'h0104, refCnt);
      chk({31'h0, refCnt != 32'h0}, 32'h1);
      pv = 35'h7FFFFFFFE;
      waitCyc(4);
      pv = 35'h0;
      waitCyc(4);
      rdChk(16'h0104, refCnt);
      rdChk(16'h0108, 32'h2);
      wr(16'h0110, 32'h5A);
      rdChk(16'h0110, 32'h3);
      rdChk(16'h0100, 32'h1);
      wr(16'h0100, 32'h0);
      wr(16'h0100, 32'h1);
      rdChk(16'h0108, 32'h0);
      rdChk(16'h018C, 32'h0);
      $display("scaler test done");
      wrap_up();
   end
endmodule
